/* File: common/bfm_pkg.sv */
// bfm_pkg: constants, register map, enumerations and carriers of the breaker failure monitor.
// assumes a 50 MHz system clock and magnitudes in units of 0.001 x nominal current.
package bfm_pkg;

    // clock and processing tick
    localparam int CLK_FREQ_MHZ = 50;
    localparam int TICK_PERIOD_US = 5000;
    localparam int TICK_CYCLES = TICK_PERIOD_US * CLK_FREQ_MHZ;

    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int MAG_W = 16;
    localparam int PTHR_W = 12;
    localparam int TMR_W = 19;
    localparam int CMP_W = 24;

    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_PHASE_THR = 8'h04;
    localparam logic [ADDR_W-1:0] REG_RES_THR = 8'h08;
    localparam logic [ADDR_W-1:0] REG_RETRIP_DLY = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_BF_DLY = 8'h10;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;

    // control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SRC_LSB = 4;
    localparam int CTRL_RETRIP_EN_BIT = 8;

    // status field positions
    localparam int ST_COND_LSB = 0;
    localparam int ST_START_BIT = 3;
    localparam int ST_BLOCKED_BIT = 4;
    localparam int ST_RETRIP_BIT = 5;
    localparam int ST_BF_BIT = 6;
    localparam int ST_PICKUP_BIT = 7;
    localparam int ST_BLK_CYCLE_BIT = 8;

    // reset values: thresholds in setting steps, delays in 5 ms ticks
    localparam logic [PTHR_W-1:0] PHASE_THR_RST = 12'h014;
    localparam logic [MAG_W-1:0] RES_THR_RST = 16'h04b0;
    localparam logic [TMR_W-1:0] RETRIP_DLY_RST = 19'h00014;
    localparam logic [TMR_W-1:0] BF_DLY_RST = 19'h00028;
    localparam logic RETRIP_EN_RST = 1'b1;

    // threshold scaling and hysteresis
    localparam logic [CMP_W-1:0] PHASE_STEP_SCALE = 24'h00000a;
    localparam logic [CMP_W-1:0] HYST_PCT = 24'h000061;
    localparam logic [CMP_W-1:0] FULL_PCT = 24'h000064;

    typedef enum logic [3:0] {
        MODE_CUR_ONLY, MODE_DO_ONLY, MODE_SIG_ONLY, MODE_CUR_AND_DO, MODE_CUR_AND_SIG,
        MODE_SIG_AND_DO, MODE_SIG_OR_DO, MODE_CUR_OR_DO, MODE_CUR_OR_SIG,
        MODE_CUR_OR_SIG_OR_DO, MODE_CUR_AND_SIG_AND_DO
    } bfm_mode_t;

    typedef enum logic [1:0] {SRC_UNUSED, SRC_FIRST, SRC_SECOND, SRC_CALC} bfm_src_t;

    typedef enum logic [2:0] {
        COND_NORMAL, COND_START, COND_RETRIP, COND_BF, COND_ON, COND_BLOCKED
    } bfm_cond_t;

    typedef struct packed {
        logic [MAG_W-1:0] phase_a;
        logic [MAG_W-1:0] phase_b;
        logic [MAG_W-1:0] phase_c;
        logic [MAG_W-1:0] first_residual_input;
        logic [MAG_W-1:0] second_residual_input;
        logic [MAG_W-1:0] calculated_residual;
    } bfm_meas_t;

    typedef struct packed {
        logic signal_trip;
        logic relay_trip;
        logic block;
    } bfm_bin_t;

    typedef struct packed {
        logic start;
        logic blocked;
        logic retrip;
        logic breaker_failure_output;
    } bfm_trip_t;

endpackage

/* File: rtl/bfm_monitor.sv */
// bfm_monitor: breaker failure monitor with current pick-up, mode logic, blocking and two timers.
// assumes inputs synchronous to clk_in; register master as a plain one-cycle strobe port.
//
// Behaviour
// - pick-up on any phase or residual over threshold
// - release only below 97 percent of threshold
// - one phase threshold shared by three phases
// - residual source selectable, unused after reset
// - operating mode selects current, signal, relay combinations
// - phase threshold 0.01 steps, default 0.20
// - residual threshold 0.001 steps, default 1.200
// - blocking sampled once per processing tick
// - unblocked pick-up raises start, runs timers
// - blocked pick-up raises blocked, timers stay idle
// - late blocking clears start and resets timers
// - both timers started by same pick-up
// - retrip enable setting, default on
// - retrip after retrip delay, default 0.100 s
// - breaker failure after its delay, default 0.200 s
// - readable condition value with six states
// - settings writable while running
// - current mode resets timers when currents drop
// - current-and-relay mode halts timers until relay
// - current-or-relay mode resets only when both clear
//
// The implementer's own choices: the address map and the plain strobed port.
module bfm_monitor
    import bfm_pkg::*;
#(
    parameter int TICK_CYCLES_P = bfm_pkg::TICK_CYCLES
)(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // register port
    input wire logic [bfm_pkg::ADDR_W-1:0] addr_in,
    input wire logic [bfm_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [bfm_pkg::DATA_W-1:0] rdata_out,
    // measurements and binary signals
    input wire bfm_pkg::bfm_meas_t meas_in,
    input wire bfm_pkg::bfm_bin_t bin_in,
    // trip outputs
    output bfm_pkg::bfm_trip_t trip_out,
    output bfm_pkg::bfm_cond_t cond_out
);
    import bfm_pkg::*;

    localparam int NCMP = 4;

    // settings
    bfm_mode_t mode;
    bfm_src_t res_src;
    logic retrip_en;
    logic [PTHR_W-1:0] phase_thr;
    logic [MAG_W-1:0] res_thr;
    logic [TMR_W-1:0] retrip_dly;
    logic [TMR_W-1:0] bf_dly;

    // processing state
    logic [$clog2(TICK_CYCLES_P)-1:0] div_cnt;
    logic tick;
    logic [NCMP-1:0] pk;
    logic [NCMP-1:0] next_pk;
    logic [MAG_W-1:0] cmp_mag [NCMP];
    logic [CMP_W-1:0] cmp_thr [NCMP];
    logic [NCMP-1:0] cmp_en;
    logic cur_pk;
    logic pickup;
    logic run;
    logic run_q;
    logic blk_cycle;
    logic [TMR_W-1:0] rt_cnt;
    logic [TMR_W-1:0] bf_cnt;
    logic [TMR_W-1:0] next_rt_cnt;
    logic [TMR_W-1:0] next_bf_cnt;
    logic next_start;
    logic next_blocked;
    bfm_trip_t trip;

    // above threshold sets, below the reset ratio clears, otherwise hold
    function automatic logic hyst_cmp(input logic prev, input logic [MAG_W-1:0] mag,
                                      input logic [CMP_W-1:0] thr);
        logic [CMP_W-1:0] m;
        m = {{(CMP_W-MAG_W){1'b0}}, mag};
        if (m > thr)
            return 1'b1;
        else if (CMP_W'(m * FULL_PCT) < CMP_W'(thr * HYST_PCT))
            return 1'b0;
        else
            return prev;
    endfunction

    // timer start/run term from the selected mode
    function automatic logic mode_term(input bfm_mode_t m, input logic c, input logic s,
                                       input logic d);
        case (m)
            MODE_CUR_ONLY: return c;
            MODE_DO_ONLY: return d;
            MODE_SIG_ONLY: return s;
            MODE_CUR_AND_DO: return c & d;
            MODE_CUR_AND_SIG: return c & s;
            MODE_SIG_AND_DO: return s & d;
            MODE_SIG_OR_DO: return s | d;
            MODE_CUR_OR_DO: return c | d;
            MODE_CUR_OR_SIG: return c | s;
            MODE_CUR_OR_SIG_OR_DO: return c | s | d;
            MODE_CUR_AND_SIG_AND_DO: return c & s & d;
            default: return c;
        endcase
    endfunction

    function automatic logic [TMR_W-1:0] sat_inc(input logic [TMR_W-1:0] v);
        return (v == {TMR_W{1'b1}}) ? v : TMR_W'(v + 1'b1);
    endfunction

    // processing tick divider
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            div_cnt <= '0;
        else if (tick)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    assign tick = (div_cnt == ($clog2(TICK_CYCLES_P))'(TICK_CYCLES_P - 1));

    // settings registers; a write takes effect on the next tick, except that clearing retrip enable drops retrip at once
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            mode <= MODE_CUR_ONLY;
            res_src <= SRC_UNUSED;
            retrip_en <= RETRIP_EN_RST;
            phase_thr <= PHASE_THR_RST;
            res_thr <= RES_THR_RST;
            retrip_dly <= RETRIP_DLY_RST;
            bf_dly <= BF_DLY_RST;
        end
        else if (wr_in)
        begin
            case (addr_in)
                REG_CTRL:
                begin
                    mode <= bfm_mode_t'(wdata_in[CTRL_MODE_LSB +: 4]);
                    res_src <= bfm_src_t'(wdata_in[CTRL_SRC_LSB +: 2]);
                    retrip_en <= wdata_in[CTRL_RETRIP_EN_BIT];
                end
                REG_PHASE_THR: phase_thr <= wdata_in[PTHR_W-1:0];
                REG_RES_THR: res_thr <= wdata_in[MAG_W-1:0];
                REG_RETRIP_DLY: retrip_dly <= wdata_in[TMR_W-1:0];
                REG_BF_DLY: bf_dly <= wdata_in[TMR_W-1:0];
                default: ;
            endcase
        end
    end

    // comparator inputs: three phases share one scaled threshold
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            cmp_thr[i] = CMP_W'({{(CMP_W-PTHR_W){1'b0}}, phase_thr} * PHASE_STEP_SCALE);
            cmp_en[i] = 1'b1;
        end
        cmp_mag[0] = meas_in.phase_a;
        cmp_mag[1] = meas_in.phase_b;
        cmp_mag[2] = meas_in.phase_c;
        cmp_thr[3] = {{(CMP_W-MAG_W){1'b0}}, res_thr};
        cmp_en[3] = (res_src != SRC_UNUSED);
        case (res_src)
            SRC_FIRST: cmp_mag[3] = meas_in.first_residual_input;
            SRC_SECOND: cmp_mag[3] = meas_in.second_residual_input;
            SRC_CALC: cmp_mag[3] = meas_in.calculated_residual;
            default: cmp_mag[3] = '0;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < NCMP; g++)
        begin : g_cmp
            assign next_pk[g] = cmp_en[g] & hyst_cmp(pk[g], cmp_mag[g], cmp_thr[g]);
        end
    endgenerate

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            pk <= '0;
        else if (tick)
            pk <= next_pk;
    end

    // start and timer terms, evaluated with this tick's comparator result
    always_comb
    begin
        cur_pk = |next_pk;
        run = mode_term(mode, cur_pk, bin_in.signal_trip, bin_in.relay_trip);
        if (mode == MODE_CUR_AND_DO)
            pickup = cur_pk;
        else
            pickup = run;
        next_start = trip.start;
        next_blocked = trip.blocked;
        next_rt_cnt = rt_cnt;
        next_bf_cnt = bf_cnt;
        if (tick)
        begin
            if (!pickup)
            begin
                next_start = 1'b0;
                next_blocked = 1'b0;
                next_rt_cnt = '0;
                next_bf_cnt = '0;
            end
            else if (bin_in.block)
            begin
                next_start = 1'b0;
                next_blocked = 1'b1;
                next_rt_cnt = '0;
                next_bf_cnt = '0;
            end
            else
            begin
                next_start = 1'b1;
                next_blocked = 1'b0;
                // halted counters are cleared rather than frozen, so a relay
                // that drops and returns restarts the full delay
                if (run && trip.start)
                begin
                    next_rt_cnt = sat_inc(rt_cnt);
                    next_bf_cnt = sat_inc(bf_cnt);
                end
                else
                begin
                    next_rt_cnt = '0;
                    next_bf_cnt = '0;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rt_cnt <= '0;
            bf_cnt <= '0;
            run_q <= 1'b0;
            blk_cycle <= 1'b0;
        end
        else if (tick)
        begin
            rt_cnt <= next_rt_cnt;
            bf_cnt <= next_bf_cnt;
            run_q <= run;
            blk_cycle <= bin_in.block;
        end
    end

    // outputs change on ticks, except that disabling retrip drops it at once
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            trip <= '0;
        else
        begin
            if (tick)
            begin
                trip.start <= next_start;
                trip.blocked <= next_blocked;
                trip.breaker_failure_output <= next_start & run
                    & (next_bf_cnt >= bf_dly);
            end
            if (!retrip_en)
                trip.retrip <= 1'b0;
            else if (tick)
                trip.retrip <= next_start & run & (next_rt_cnt >= retrip_dly);
        end
    end

    assign trip_out = trip;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            cond_out <= COND_NORMAL;
        else if (tick)
        begin
            if (next_blocked)
                cond_out <= COND_BLOCKED;
            else if (next_start && run && next_bf_cnt >= bf_dly)
                cond_out <= COND_BF;
            else if (next_start && run && retrip_en && next_rt_cnt >= retrip_dly)
                cond_out <= COND_RETRIP;
            else if (next_start && run)
                cond_out <= COND_START;
            else if (next_start)
                cond_out <= COND_ON;
            else
                cond_out <= COND_NORMAL;
        end
    end

    // read data valid only in the cycle after the read strobe
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rdata_out <= '0;
        else if (rd_in)
        begin
            rdata_out <= '0;
            case (addr_in)
                REG_CTRL:
                begin
                    rdata_out[CTRL_MODE_LSB +: 4] <= mode;
                    rdata_out[CTRL_SRC_LSB +: 2] <= res_src;
                    rdata_out[CTRL_RETRIP_EN_BIT] <= retrip_en;
                end
                REG_PHASE_THR: rdata_out[PTHR_W-1:0] <= phase_thr;
                REG_RES_THR: rdata_out[MAG_W-1:0] <= res_thr;
                REG_RETRIP_DLY: rdata_out[TMR_W-1:0] <= retrip_dly;
                REG_BF_DLY: rdata_out[TMR_W-1:0] <= bf_dly;
                REG_STATUS:
                begin
                    rdata_out[ST_COND_LSB +: 3] <= cond_out;
                    rdata_out[ST_START_BIT] <= trip.start;
                    rdata_out[ST_BLOCKED_BIT] <= trip.blocked;
                    rdata_out[ST_RETRIP_BIT] <= trip.retrip;
                    rdata_out[ST_BF_BIT] <= trip.breaker_failure_output;
                    rdata_out[ST_PICKUP_BIT] <= |pk;
                    rdata_out[ST_BLK_CYCLE_BIT] <= blk_cycle;
                end
                default: ;
            endcase
        end
        else
            rdata_out <= '0;
    end

    // checks
    sequence s_tick_pick_free;
        tick && pickup && !bin_in.block;
    endsequence

    sequence s_started_idle;
        trip.start && rt_cnt == '0 && bf_cnt == '0;
    endsequence

    property p_start_free;
        @(posedge clk_in) disable iff (!resetn_in)
        s_tick_pick_free |=> s_started_idle or (trip.start && rt_cnt != '0);
    endproperty
    a_start_free: assert property (p_start_free) else $error("start missing");

    property p_blocked;
        @(posedge clk_in) disable iff (!resetn_in)
        tick && pickup && bin_in.block
            |=> trip.blocked && !trip.start && rt_cnt == '0 && bf_cnt == '0;
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked pick-up ran timers");

    property p_late_block;
        @(posedge clk_in) disable iff (!resetn_in)
        trip.start && tick && bin_in.block |=> !trip.start && !trip.retrip;
    endproperty
    a_late_block: assert property (p_late_block) else $error("start kept under block");

    property p_drop;
        @(posedge clk_in) disable iff (!resetn_in)
        tick && !pickup |=> !trip.start && !trip.breaker_failure_output && bf_cnt == '0;
    endproperty
    a_drop: assert property (p_drop) else $error("timers kept after drop-out");

    property p_retrip_time;
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(trip.retrip) |-> trip.start && retrip_en && rt_cnt >= retrip_dly;
    endproperty
    a_retrip_time: assert property (p_retrip_time) else $error("early retrip");

    property p_bf_time;
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(trip.breaker_failure_output) |-> trip.start && bf_cnt >= bf_dly;
    endproperty
    a_bf_time: assert property (p_bf_time) else $error("early breaker failure");

    property p_retrip_off;
        @(posedge clk_in) disable iff (!resetn_in)
        !retrip_en |=> !trip.retrip;
    endproperty
    a_retrip_off: assert property (p_retrip_off) else $error("retrip while disabled");

    property p_same_start;
        @(posedge clk_in) disable iff (!resetn_in)
        $rose(trip.start) |-> rt_cnt == bf_cnt;
    endproperty
    a_same_start: assert property (p_same_start) else $error("timers started apart");

    property p_blk_hold;
        @(posedge clk_in) disable iff (!resetn_in)
        !tick |=> $stable(blk_cycle);
    endproperty
    a_blk_hold: assert property (p_blk_hold) else $error("block sampled off tick");

    property p_halt;
        @(posedge clk_in) disable iff (!resetn_in)
        mode == MODE_CUR_AND_DO && trip.start && !run_q |-> rt_cnt == '0 && bf_cnt == '0;
    endproperty
    a_halt: assert property (p_halt) else $error("timers ran before relay");

    property p_hyst;
        @(posedge clk_in) disable iff (!resetn_in)
        tick && pk[0] && CMP_W'(meas_in.phase_a * FULL_PCT) >= CMP_W'(cmp_thr[0] * HYST_PCT)
            |=> pk[0];
    endproperty
    a_hyst: assert property (p_hyst) else $error("pick-up released inside band");

endmodule // bfm_monitor

/* File: verification/bfm_field_model.sv */
// bfm_field_model: measurement front end, protection stages and breaker for the monitor.
// assumes the bench commands levels; the breaker opens on retrip when allowed to.
module bfm_field_model
    import bfm_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic resetn_in,
    // commanded levels
    input wire bfm_pkg::bfm_meas_t level_in,
    input wire bfm_pkg::bfm_bin_t bin_level_in,
    input wire logic opens_in,
    // trip coil side
    input wire bfm_pkg::bfm_trip_t trip_in,
    // to the monitor
    output bfm_pkg::bfm_meas_t meas_out,
    output bfm_pkg::bfm_bin_t bin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import bfm_pkg::*;

    logic opened;

    // an opened breaker stays open until the bench withdraws its permission
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            opened <= 1'b0;
        else
            opened <= opens_in && (opened || trip_in.retrip);
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            meas_out <= '0;
            bin_out <= '0;
        end
        else
        begin
            meas_out <= opened ? '0 : level_in;
            bin_out <= bin_level_in;
        end
    end
endmodule // bfm_field_model

/* File: verification/tb_top.sv */
// tb_top: self-checking bench of the breaker failure monitor with a short tick.
// assumes outputs change only at ticks, so stimulus and checks sit mid-tick.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import bfm_pkg::*;

    localparam int TK = 8;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [ADDR_W-1:0] addr_in = '0;
    logic [DATA_W-1:0] wdata_in = '0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [DATA_W-1:0] rdata_out;
    bfm_meas_t meas_in;
    bfm_meas_t lvl = '0;
    bfm_bin_t bin_in;
    bfm_bin_t bin_lvl = '0;
    logic opens = 1'b0;
    bfm_trip_t trip_out;
    bfm_cond_t cond_out;
    int err_count = 0;
    int checks_done = 0;
    int cyc = 0;

    always #10 clk_in = ~clk_in;
    always @(posedge clk_in)
        if (resetn_in)
            cyc <= cyc + 1;

    bfm_monitor #(.TICK_CYCLES_P(TK)) DUT (.clk_in(clk_in), .resetn_in(resetn_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .meas_in(meas_in), .bin_in(bin_in), .trip_out(trip_out),
        .cond_out(cond_out));
    bfm_field_model FM (.clk_in(clk_in), .resetn_in(resetn_in), .level_in(lvl),
        .bin_level_in(bin_lvl), .opens_in(opens), .trip_in(trip_out), .meas_out(meas_in),
        .bin_out(bin_in));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask

    // stimulus lands mid-tick so a tick never sees it half changed
    task automatic set(input bfm_meas_t m, input logic [2:0] b);
        @(posedge clk_in);
        while (cyc % TK != 4)
            @(posedge clk_in);
        lvl <= m;
        bin_lvl <= bfm_bin_t'(b);
    endtask

    task automatic ticks(input int n);
        repeat (n * TK) @(posedge clk_in);
    endtask

    task automatic chk_out(input logic [3:0] t, input bfm_cond_t c);
        chk("trip", {28'h0, trip_out}, {28'h0, t});
        chk("cond", {29'h0, cond_out}, {29'h0, c});
    endtask

    task automatic pick(input logic p);
        logic [31:0] v;
        rd(REG_STATUS, v);
        chk("pickup", {31'h0, v[ST_PICKUP_BIT]}, {31'h0, p});
    endtask

    task automatic s_defaults;
        logic [7:0] a [6] = '{REG_CTRL, REG_PHASE_THR, REG_RES_THR, REG_RETRIP_DLY,
            REG_BF_DLY, 8'h18};
        logic [31:0] e [6] = '{32'h100, 32'h14, 32'h4b0, 32'h14, 32'h28, 32'h0};
        logic [31:0] v;
        wr(8'h18, 32'hffffffff);
        wr(REG_STATUS, 32'hffffffff);
        for (int i = 0; i < 6; i++)
        begin
            rd(a[i], v);
            chk("reg", v, e[i]);
        end
        rd(REG_STATUS, v);
        chk("status", v, 32'h0);
    endtask

    task automatic s_pickup;
        logic [47:0] m [9] = '{{16'd0, 16'd201, 16'd0}, {16'd0, 16'd195, 16'd0},
            {16'd0, 16'd194, 16'd0}, {16'd0, 16'd193, 16'd0}, {16'd0, 16'd200, 16'd0},
            {16'd0, 16'd0, 16'd201}, {16'd0, 16'd0, 16'd193}, {3{16'd201}}, 48'h0};
        logic p [9] = '{1, 1, 1, 0, 0, 1, 0, 1, 0};
        for (int i = 0; i < 9; i++)
        begin
            set({m[i], 48'h0}, 3'b000);
            ticks(1);
            chk_out({p[i], 3'b000}, p[i] ? COND_START : COND_NORMAL);
            pick(p[i]);
        end
    endtask

    task automatic s_residual;
        wr(REG_RES_THR, 32'h64);
        for (int s = 0; s < 4; s++)
        begin
            wr(REG_CTRL, 32'h100 | (s << CTRL_SRC_LSB));
            for (int j = 1; j < 4; j++)
            begin
                set({48'h0, 48'(16'd150) << (16 * (3 - j))}, 3'b000);
                ticks(1);
                pick(s == j);
            end
        end
        set('0, 3'b000);
        wr(REG_CTRL, 32'h100);
        wr(REG_RES_THR, 32'h4b0);
        ticks(1);
    endtask

    task automatic s_timers;
        wr(REG_RETRIP_DLY, 32'h3);
        wr(REG_BF_DLY, 32'h6);
        set({16'd0, 16'd300, 64'h0}, 3'b000);
        ticks(1);
        chk_out(4'b1000, COND_START);
        ticks(2);
        chk_out(4'b1000, COND_START);
        ticks(1);
        chk_out(4'b1010, COND_RETRIP);
        ticks(3);
        chk_out(4'b1011, COND_BF);
        ticks(2);
        chk_out(4'b1011, COND_BF);
        set('0, 3'b000);
        ticks(1);
        chk_out(4'b0000, COND_NORMAL);
    endtask

    task automatic s_block;
        logic [31:0] v;
        set({16'd0, 16'd300, 64'h0}, 3'b001);
        ticks(1);
        chk_out(4'b0100, COND_BLOCKED);
        // cond blocked, blocked flag, pick-up and sampled block all visible
        rd(REG_STATUS, v);
        chk("status", v, 32'h195);
        ticks(6);
        chk_out(4'b0100, COND_BLOCKED);
        set({16'd0, 16'd300, 64'h0}, 3'b000);
        ticks(2);
        // blocking is in place at the tick that would have fired retrip
        set({16'd0, 16'd300, 64'h0}, 3'b001);
        ticks(1);
        chk_out(4'b0100, COND_BLOCKED);
        set({16'd0, 16'd300, 64'h0}, 3'b000);
        ticks(3);
        chk_out(4'b1000, COND_START);
        // a block pulse between ticks must go unseen
        // one clock wide, so the model shows it only on a non-tick edge
        bin_lvl.block <= 1'b1;
        @(posedge clk_in);
        bin_lvl.block <= 1'b0;
        ticks(1);
        chk_out(4'b1010, COND_RETRIP);
        set('0, 3'b000);
        ticks(1);
    endtask

    task automatic s_no_retrip;
        wr(REG_CTRL, 32'h0);
        set({16'd0, 16'd300, 64'h0}, 3'b000);
        ticks(4);
        chk_out(4'b1000, COND_START);
        ticks(3);
        chk_out(4'b1001, COND_BF);
        set('0, 3'b000);
        wr(REG_CTRL, 32'h100);
        ticks(1);
    endtask

    task automatic s_opens;
        opens <= 1'b1;
        set({16'd0, 16'd300, 64'h0}, 3'b000);
        ticks(4);
        chk_out(4'b1010, COND_RETRIP);
        ticks(1);
        chk_out(4'b0000, COND_NORMAL);
        ticks(3);
        chk_out(4'b0000, COND_NORMAL);
        set('0, 3'b000);
        opens <= 1'b0;
    endtask

    task automatic s_modes;
        wr(REG_CTRL, 32'h100 | MODE_CUR_AND_DO);
        set({16'd0, 16'd300, 64'h0}, 3'b000);
        ticks(5);
        chk_out(4'b1000, COND_ON);
        set({16'd0, 16'd300, 64'h0}, 3'b010);
        ticks(2);
        chk_out(4'b1000, COND_START);
        ticks(3);
        chk_out(4'b1010, COND_RETRIP);
        set({16'd0, 16'd300, 64'h0}, 3'b000);
        ticks(1);
        chk_out(4'b1000, COND_ON);
        wr(REG_CTRL, 32'h100 | MODE_CUR_OR_DO);
        set('0, 3'b010);
        ticks(1);
        chk_out(4'b1000, COND_START);
        set({16'd0, 16'd300, 64'h0}, 3'b000);
        // the tick inside set already counted on the relay alone
        ticks(2);
        chk_out(4'b1010, COND_RETRIP);
        set('0, 3'b000);
        ticks(1);
        chk_out(4'b0000, COND_NORMAL);
        wr(REG_CTRL, 32'h100 | MODE_SIG_ONLY);
        set('0, 3'b100);
        ticks(1);
        chk_out(4'b1000, COND_START);
        set({16'd0, 16'd300, 64'h0}, 3'b000);
        ticks(1);
        chk_out(4'b0000, COND_NORMAL);
        wr(REG_CTRL, 32'h100);
    endtask

    initial
    begin
        repeat (20000) @(posedge clk_in);
        err_count++;
        print_verdict();
    end

    initial
    begin
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
        s_defaults();
        s_pickup();
        s_residual();
        s_timers();
        s_block();
        s_no_retrip();
        s_opens();
        s_modes();
        print_verdict();
    end
endmodule // tb_top
